//--- panel_indicator_controller_tb.sv
// Self-checking bench for the panel indicator controller
module panel_indicator_controller_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import pic_pkg::*;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	pic_stat_t cmd;
	pic_stat_t stat;
	pic_lamp_t lamps;
	logic far_t1 = 1'b0;
	logic far_e1 = 1'b0;
	logic [31:0] rd;
	logic er;
	int failures = 0;
	int compares = 0;
	always #25 sys_clk = ~sys_clk;
	pic_far_model pic_far_model_inst (.sys_clk(sys_clk), .rst_n(rst_n), .cmd(cmd),
		.far_t1_alarm(far_t1), .far_e1_loss(far_e1), .stat(stat));
	pic_ctrl #(.QUAL_CYC(20), .STRETCH_CYC(5), .BLINK_CYC(4), .TEST_CYC(10)) pic_ctrl_inst (
		.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .stat_in(stat), .lamps(lamps));
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// Called just after a rising edge; holds the request until pready is sampled
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			failures++;
			$display("[ERR] apb ready expected 1 seen %0h", pready);
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// One idle edge so a following call never reassigns psel in this time step
		@(posedge sys_clk);
	endtask
	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic t_boot();
		cyc(2);
		@(negedge sys_clk);
		chk("test lamps", 32'(lamps), 32'h000FFFFF);
		cyc(15);
		@(negedge sys_clk);
		chk("after test", 32'(lamps), 32'h00080000);
		@(posedge sys_clk);
		apb(1'b0, ADDR_STATE, 32'h0);
		chk("state", rd, 32'h3);
		apb(1'b0, 12'h00C, 32'h0);
		chk("unmapped err", 32'(er), 32'h1);
		$display("Test boot done");
	endtask
	task automatic t_level();
		cmd.pkt_ok <= 1'b1;
		cmd.lan_err <= 2'b10;
		cmd.sw_up <= 4'b0100;
		cmd.lan_fast <= 1'b1;
		cmd.t1_sub_far <= 4'h2;
		cmd.e1_sub_far <= 4'h8;
		far_t1 <= 1'b1;
		far_e1 <= 1'b1;
		cyc(5);
		@(negedge sys_clk);
		chk("ready", 32'(lamps.ready_lamp), 32'h1);
		chk("lan err", 32'(lamps.lan_err_lamp), 32'h2);
		chk("eth", 32'(lamps.eth_link_lamp), 32'h1);
		chk("fast", 32'(lamps.fast_speed_lamp), 32'h1);
		chk("t1 yel", 32'({lamps.t1_yel_lamp, lamps.t1_sub_yel_lamp}), 32'h3);
		chk("e1 far", 32'({lamps.main_far_sync_fail_lamp, lamps.sub_far_sync_fail_lamp}),
			32'h3);
		@(posedge sys_clk);
		cmd.lan_err <= 2'b00;
		cmd.sw_up <= 4'h0;
		cmd.lan_fast <= 1'b0;
		cmd.t1_sub_far <= 4'h0;
		cmd.e1_sub_far <= 4'h0;
		far_t1 <= 1'b0;
		far_e1 <= 1'b0;
		cyc(5);
		apb(1'b0, ADDR_LAMPS, 32'h0);
		chk("lamps reg", rd, 32'h000C0000);
		$display("Test level done");
	endtask
	task automatic t_pulse();
		cmd.lan_pkt <= 2'b01;
		cmd.link_pkt <= 2'b10;
		cmd.link_err <= 2'b01;
		@(posedge sys_clk);
		cmd.lan_pkt <= 2'b00;
		cmd.link_pkt <= 2'b00;
		cmd.link_err <= 2'b00;
		cyc(4);
		@(negedge sys_clk);
		chk("lan act", 32'(lamps.lan_act_lamp), 32'h1);
		chk("link act", 32'(lamps.link_act_lamp), 32'h2);
		chk("link err", 32'(lamps.link_err_lamp), 32'h1);
		cyc(8);
		@(negedge sys_clk);
		chk("stretch end", 32'({lamps.lan_act_lamp, lamps.link_act_lamp,
			lamps.link_err_lamp}), 32'h0);
		@(posedge sys_clk);
		cmd.link_phys <= 2'b01;
		cyc(12);
		@(negedge sys_clk);
		chk("no phys", 32'(lamps.link_err_lamp), 32'h2);
		@(posedge sys_clk);
		cmd.link_phys <= 2'b11;
		$display("Test pulse done");
	endtask
	task automatic t_qual();
		cmd.t1_los <= 1'b1;
		cmd.t1_sub_los <= 4'h8;
		cmd.e1_los <= 1'b1;
		cmd.e1_sub_los <= 4'h4;
		cyc(15);
		@(negedge sys_clk);
		chk("early", 32'({lamps.t1_red_lamp, lamps.t1_sub_red_lamp,
			lamps.main_local_sync_fail_lamp, lamps.sub_local_sync_fail_lamp}), 32'h0);
		cyc(20);
		@(negedge sys_clk);
		chk("alarm", 32'({lamps.t1_red_lamp, lamps.t1_sub_red_lamp,
			lamps.main_local_sync_fail_lamp, lamps.sub_local_sync_fail_lamp}), 32'hF);
		@(posedge sys_clk);
		cmd.t1_los <= 1'b0;
		cmd.t1_sub_los <= 4'h0;
		cmd.e1_los <= 1'b0;
		cmd.e1_sub_los <= 4'h0;
		cyc(5);
		@(negedge sys_clk);
		chk("cleared", 32'({lamps.t1_red_lamp, lamps.main_local_sync_fail_lamp}), 32'h0);
		@(posedge sys_clk);
		$display("Test qual done");
	endtask
	task automatic t_blink();
		int tog;
		logic last;
		tog = 0;
		cmd.loop_on <= 1'b1;
		cyc(5);
		@(negedge sys_clk);
		last = lamps.ready_lamp;
		repeat (24) begin
			@(negedge sys_clk);
			if (lamps.ready_lamp !== last) tog++;
			last = lamps.ready_lamp;
		end
		// Half period of 4 cycles gives six changes in 24 cycles, one either way for phase
		chk("blink", 32'(tog >= 5 && tog <= 7), 32'h1);
		@(posedge sys_clk);
		cmd.loop_on <= 1'b0;
		cyc(5);
		apb(1'b1, ADDR_CTRL, 32'h1);
		cyc(4);
		@(negedge sys_clk);
		chk("force", 32'(lamps), 32'h000FFFFF);
		@(posedge sys_clk);
		apb(1'b1, ADDR_LAMPS, 32'h0);
		chk("ro write", 32'(er), 32'h1);
		apb(1'b1, ADDR_CTRL, 32'h2);
		cyc(3);
		@(negedge sys_clk);
		chk("retest", 32'(lamps), 32'h000FFFFF);
		cyc(20);
		@(negedge sys_clk);
		chk("resume", 32'(lamps), 32'h000C0000);
		$display("Test blink and control done");
	endtask
	initial begin
		cmd = '0;
		cmd.link_phys = 2'b11;
		cyc(20);
		rst_n <= 1'b1;
		t_boot();
		t_level();
		t_pulse();
		t_qual();
		t_blink();
		give_verdict();
	end
	// Whole run needs well under 600 cycles
	initial begin
		cyc(5000);
		failures++;
		give_verdict();
	end
endmodule

//--- pic_ctrl.sv
// Panel indicator controller: lamp logic, qualifiers, lamp test, APB slave
//
// Design decisions made here: the APB slave port and the placing of the registers.
module pic_ctrl #(
	parameter int unsigned QUAL_CYC = pic_pkg::QUAL_CYC_DEF,
	parameter int unsigned STRETCH_CYC = pic_pkg::STRETCH_CYC_DEF,
	parameter int unsigned BLINK_CYC = pic_pkg::BLINK_CYC_DEF,
	parameter int unsigned TEST_CYC = pic_pkg::TEST_CYC_DEF
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire pic_pkg::pic_stat_t stat_in,
	output pic_pkg::pic_lamp_t lamps
);
	import pic_pkg::*;

	localparam int QN = 2 + 2 * NSUB;
	localparam int SN = 2 * NLINK + NLAN;
	localparam int QW = $clog2(QUAL_CYC + 1);
	localparam int SW = $clog2(STRETCH_CYC + 1);
	localparam int BW = $clog2(BLINK_CYC + 1);
	localparam int TW = $clog2(TEST_CYC + 1);
	localparam int LW = $bits(pic_lamp_t);

	if (QUAL_CYC < 1 || STRETCH_CYC < 1 || BLINK_CYC < 1 || TEST_CYC < 1) begin : g_bad
		$error("pic_ctrl: every count must be at least one cycle");
	end

	function automatic pic_sel_t pic_dec(input logic [11:0] a);
		if (a == ADDR_CTRL) begin
			return SEL_CTRL;
		end else if (a == ADDR_LAMPS) begin
			return SEL_LAMPS;
		end else if (a == ADDR_STATE) begin
			return SEL_STATE;
		end else begin
			return SEL_NONE;
		end
	endfunction

	pic_stat_t stat_m;
	pic_stat_t stat_s;
	pic_lamp_t lamps_d;
	pic_lamp_t lamps_q;
	pic_state_t st_q;
	logic [TW-1:0] tcnt_q;
	logic [BW-1:0] bcnt_q;
	logic blink_q;
	logic force_q;
	logic retest_q;
	logic [31:0] prdata_q;
	logic pslverr_q;
	logic [QN-1:0] qloss;
	logic [QN-1:0] qal_q;
	logic [QW-1:0] qcnt_q [QN];
	logic [SN-1:0] sev;
	logic [SN-1:0] son;
	logic [SW-1:0] scnt_q [SN];
	logic run;
	logic setup;
	logic acc;

	// Status pins come from other clock domains
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			stat_m <= '0;
			stat_s <= '0;
		end else begin
			stat_m <= stat_in;
			stat_s <= stat_m;
		end
	end

	// Free-running divider, equal halves
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			bcnt_q <= '0;
			blink_q <= 1'b0;
		end else if (bcnt_q == BW'(BLINK_CYC - 1)) begin
			bcnt_q <= '0;
			blink_q <= ~blink_q;
		end else begin
			bcnt_q <= bcnt_q + BW'(1);
		end
	end

	// Lamp test sequence
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= ST_TEST;
			tcnt_q <= TW'(TEST_CYC - 1);
		end else begin
			case (st_q)
				ST_TEST: begin
					if (tcnt_q == '0) begin
						st_q <= ST_DARK;
					end else begin
						tcnt_q <= tcnt_q - TW'(1);
					end
				end
				ST_DARK: begin
					st_q <= ST_RUN;
				end
				default: begin
					if (retest_q) begin
						st_q <= ST_TEST;
						tcnt_q <= TW'(TEST_CYC - 1);
					end
				end
			endcase
		end
	end

	assign run = (st_q == ST_RUN);

	// Frame loss qualifiers: main T1, T1 subs, main E1, E1 subs
	assign qloss = {stat_s.e1_sub_los, stat_s.e1_los, stat_s.t1_sub_los, stat_s.t1_los};

	for (genvar i = 0; i < QN; i++) begin : g_qual
		always_ff @(posedge sys_clk or negedge rst_n) begin
			if (!rst_n) begin
				qcnt_q[i] <= '0;
				qal_q[i] <= 1'b0;
			end else if (!qloss[i]) begin
				qcnt_q[i] <= '0;
				qal_q[i] <= 1'b0;
			end else if (qcnt_q[i] == QW'(QUAL_CYC)) begin
				qal_q[i] <= 1'b1;
			end else begin
				qcnt_q[i] <= qcnt_q[i] + QW'(1);
			end
		end
	end

	// Pulse stretchers: LAN activity, link activity, link error
	assign sev = {stat_s.link_err, stat_s.link_pkt, stat_s.lan_pkt};

	for (genvar i = 0; i < SN; i++) begin : g_str
		always_ff @(posedge sys_clk or negedge rst_n) begin
			if (!rst_n) begin
				scnt_q[i] <= '0;
			end else if (sev[i]) begin
				scnt_q[i] <= SW'(STRETCH_CYC);
			end else if (scnt_q[i] != '0) begin
				scnt_q[i] <= scnt_q[i] - SW'(1);
			end
		end
		assign son[i] = sev[i] | (scnt_q[i] != '0);
	end

	always_comb begin
		lamps_d = '0;
		lamps_d.supply_lamp = 1'b1;
		case (st_q)
			ST_TEST: begin
				lamps_d = '1;
			end
			ST_DARK: begin
				lamps_d.ready_lamp = stat_s.pkt_ok;
			end
			default: begin
				lamps_d.ready_lamp = stat_s.pkt_ok & (~stat_s.loop_on | blink_q);
				lamps_d.lan_act_lamp = son[NLAN-1:0];
				lamps_d.lan_err_lamp = stat_s.lan_err;
				lamps_d.link_act_lamp = son[NLAN+NLINK-1:NLAN];
				// Missing connection outranks the error pulse
				lamps_d.link_err_lamp = ~stat_s.link_phys | son[SN-1:NLAN+NLINK];
				lamps_d.t1_red_lamp = qal_q[0];
				lamps_d.t1_sub_red_lamp = |qal_q[NSUB:1];
				lamps_d.t1_yel_lamp = stat_s.t1_far;
				lamps_d.t1_sub_yel_lamp = |stat_s.t1_sub_far;
				lamps_d.main_local_sync_fail_lamp = qal_q[NSUB+1];
				lamps_d.sub_local_sync_fail_lamp = |qal_q[QN-1:NSUB+2];
				lamps_d.main_far_sync_fail_lamp = stat_s.e1_far;
				lamps_d.sub_far_sync_fail_lamp = |stat_s.e1_sub_far;
				lamps_d.eth_link_lamp = |{stat_s.lan_up, stat_s.sw_up};
				lamps_d.fast_speed_lamp = stat_s.lan_fast;
				if (force_q) begin
					lamps_d = '1;
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			lamps_q <= '0;
		end else begin
			lamps_q <= lamps_d;
		end
	end

	assign lamps = lamps_q;

	// APB slave, zero wait states; read data captured in the setup cycle
	assign setup = psel & ~penable;
	assign acc = psel & penable;
	assign pready = 1'b1;
	assign prdata = prdata_q;
	assign pslverr = pslverr_q;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata_q <= '0;
			pslverr_q <= 1'b0;
		end else if (setup) begin
			prdata_q <= '0;
			pslverr_q <= (pic_dec(paddr) == SEL_NONE) | (pwrite & (pic_dec(paddr) != SEL_CTRL));
			if (!pwrite) begin
				case (pic_dec(paddr))
					SEL_CTRL: prdata_q[CTRL_FORCE_BIT] <= force_q;
					SEL_LAMPS: prdata_q[LW-1:0] <= lamps_q;
					SEL_STATE: prdata_q[1:0] <= st_q;
					default: prdata_q <= '0;
				endcase
			end
		end
	end

	// Retest is a write-one pulse and reads back as zero
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			force_q <= CTRL_FORCE_RST;
			retest_q <= 1'b0;
		end else begin
			retest_q <= 1'b0;
			if (acc && pwrite && pic_dec(paddr) == SEL_CTRL) begin
				force_q <= pwdata[CTRL_FORCE_BIT];
				retest_q <= pwdata[CTRL_RETEST_BIT];
			end
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	// The attempt at the release edge would still see the reset value of the lamp register
	chk_supply_lamp_on: assert property (rst_n |=> lamps_q.supply_lamp)
		else $error("supply lamp dark");
	chk_ready_steady: assert property (
		run && !force_q && stat_s.pkt_ok && !stat_s.loop_on |=> lamps_q.ready_lamp)
		else $error("ready lamp not steady");
	chk_ready_blink: assert property (
		run && !force_q && stat_s.pkt_ok && stat_s.loop_on |=> lamps_q.ready_lamp == $past(blink_q))
		else $error("ready lamp not blinking");
	chk_lan_err_lamp: assert property (
		run && !force_q |=> lamps_q.lan_err_lamp == $past(stat_s.lan_err))
		else $error("lan fault lamp wrong");
	chk_link_no_phys: assert property (
		run && !stat_s.link_phys[0] |=> lamps_q.link_err_lamp[0])
		else $error("link fault lamp dark without connection");
	chk_link_fault_dark: assert property (
		run && !force_q && stat_s.link_phys[0] && !son[NLAN+2*NLINK-NLINK] |=> !lamps_q.link_err_lamp[0])
		else $error("link fault lamp lit while healthy");
	chk_qual_clear: assert property (!qloss[0] |=> !qal_q[0] && qcnt_q[0] == '0)
		else $error("qualifier not cleared");
	chk_qual_late: assert property ($rose(qal_q[0]) |-> $past(qcnt_q[0]) == QW'(QUAL_CYC))
		else $error("frame loss alarm too early");
	chk_stretch_min: assert property ($fell(son[0]) |-> $past(scnt_q[0]) == SW'(1))
		else $error("activity pulse cut short");
	chk_test_all_lit: assert property (rst_n && st_q == ST_TEST |=> lamps_q == '1)
		else $error("lamp test incomplete");
	chk_dark_step: assert property (
		st_q == ST_DARK |=> (lamps_q & ~{2'b11, (LW-2)'(0)}) == '0)
		else $error("lamps not extinguished after test");
	chk_speed_lamp: assert property (
		run && !force_q |=> lamps_q.fast_speed_lamp == $past(stat_s.lan_fast))
		else $error("speed lamp wrong");

	cov_test_to_run: cover property (st_q == ST_DARK ##1 st_q == ST_RUN);
	cov_red_alarm: cover property ($rose(qal_q[0]));
	cov_link_pulse: cover property ($fell(son[NLAN+NLINK]));
	cov_retest: cover property (run && retest_q ##1 st_q == ST_TEST);
endmodule

//--- pic_far_model.sv
// Far-side model of the LAN, link and framer status logic
module pic_far_model (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire pic_pkg::pic_stat_t cmd,
	input wire logic far_t1_alarm,
	input wire logic far_e1_loss,
	output pic_pkg::pic_stat_t stat
);
	import pic_pkg::*;
	// Far unit keeps signalling for as long as its own alarm lasts
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			stat <= '0;
		end else begin
			stat <= cmd;
			stat.t1_far <= cmd.t1_far | far_t1_alarm;
			stat.e1_far <= cmd.e1_far | far_e1_loss;
		end
	end
endmodule

//--- pic_pkg.sv
// Shared constants and carrier types for the panel indicator controller
package pic_pkg;
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
	localparam int unsigned QUAL_TIME_MS = 2500;
	localparam int unsigned STRETCH_TIME_MS = 50;
	localparam int unsigned BLINK_HALF_MS = 250;
	localparam int unsigned TEST_TIME_MS = 1000;
	localparam int unsigned QUAL_CYC_DEF = QUAL_TIME_MS * CYC_PER_MS;
	localparam int unsigned STRETCH_CYC_DEF = STRETCH_TIME_MS * CYC_PER_MS;
	localparam int unsigned BLINK_CYC_DEF = BLINK_HALF_MS * CYC_PER_MS;
	localparam int unsigned TEST_CYC_DEF = TEST_TIME_MS * CYC_PER_MS;
	localparam int NLAN = 2;
	localparam int NLINK = 2;
	localparam int NSUB = 4;
	localparam int NPORT = 4;
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_LAMPS = 12'h004;
	localparam logic [11:0] ADDR_STATE = 12'h008;
	localparam int CTRL_FORCE_BIT = 0;
	localparam int CTRL_RETEST_BIT = 1;
	localparam logic CTRL_FORCE_RST = 1'b0;
	typedef enum logic [1:0] {
		SEL_CTRL = 2'h0,
		SEL_LAMPS = 2'h1,
		SEL_STATE = 2'h2,
		SEL_NONE = 2'h3
	} pic_sel_t;
	typedef enum logic [1:0] {
		ST_TEST = 2'h0,
		ST_DARK = 2'h1,
		ST_RUN = 2'h3
	} pic_state_t;
	typedef struct packed {
		logic pkt_ok;
		logic loop_on;
		logic [NLAN-1:0] lan_pkt;
		logic [NLAN-1:0] lan_err;
		logic [NLAN-1:0] lan_up;
		logic [NPORT-1:0] sw_up;
		logic lan_fast;
		logic [NLINK-1:0] link_pkt;
		logic [NLINK-1:0] link_err;
		logic [NLINK-1:0] link_phys;
		logic t1_los;
		logic [NSUB-1:0] t1_sub_los;
		logic t1_far;
		logic [NSUB-1:0] t1_sub_far;
		logic e1_los;
		logic [NSUB-1:0] e1_sub_los;
		logic e1_far;
		logic [NSUB-1:0] e1_sub_far;
	} pic_stat_t;
	typedef struct packed {
		logic supply_lamp;
		logic ready_lamp;
		logic [NLAN-1:0] lan_act_lamp;
		logic [NLAN-1:0] lan_err_lamp;
		logic [NLINK-1:0] link_act_lamp;
		logic [NLINK-1:0] link_err_lamp;
		logic t1_red_lamp;
		logic t1_sub_red_lamp;
		logic t1_yel_lamp;
		logic t1_sub_yel_lamp;
		logic main_local_sync_fail_lamp;
		logic sub_local_sync_fail_lamp;
		logic main_far_sync_fail_lamp;
		logic sub_far_sync_fail_lamp;
		logic eth_link_lamp;
		logic fast_speed_lamp;
	} pic_lamp_t;
endpackage
